// ===== rtl/vrd_pkg.sv
package vrd_pkg;
   // clock and access timing
   localparam int CLK_NS        = 20;
   localparam int RD_LATCH_NS   = 240;
   localparam int WR_DELAY_NS   = 30;
   localparam int WR_PULSE_NS   = 120;
   localparam int RD_LATCH_CYC  = (RD_LATCH_NS + CLK_NS - 1) / CLK_NS;
   localparam int WR_DELAY_CYC  = (WR_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int WR_PULSE_CYC  = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] RD_LAST       = 4'(RD_LATCH_CYC - 1);
   localparam logic [3:0] WR_DLY_LAST   = 4'(WR_DELAY_CYC - 1);
   localparam logic [3:0] WR_PULSE_LAST = 4'(WR_PULSE_CYC - 1);
   // video ram
   localparam int VRAM_AW    = 11;
   localparam int VRAM_DEPTH = 2048;
   // character period: 8 dots of 4 clocks, phase high in first half
   localparam logic [4:0] CYC_LAST  = 5'h1f;
   localparam logic [4:0] FETCH_CYC = 5'h0f;
   localparam logic [4:0] HALF      = 5'h10;
   localparam logic [4:0] PAT_CYC   = 5'h12;
   localparam logic [4:0] SHL_START = 5'h1c;
   localparam logic [4:0] DOT_MASK  = 5'h03;
   localparam logic [3:0] ROW_ADD   = 4'hf;
   // screen formats
   localparam logic [6:0] COLS_64   = 7'h40;
   localparam logic [6:0] COLS_80   = 7'h50;
   localparam logic [6:0] H_LAST_64 = 7'h4f;
   localparam logic [6:0] H_LAST_80 = 7'h63;
   localparam logic [6:0] HS_64     = 7'h44;
   localparam logic [6:0] HS_80     = 7'h56;
   localparam logic [6:0] HS_WIDTH  = 7'h08;
   localparam logic [4:0] ROWS_16   = 5'h10;
   localparam logic [4:0] ROWS_24   = 5'h18;
   localparam logic [4:0] V_LAST_16 = 5'h15;
   localparam logic [4:0] V_LAST_24 = 5'h19;
   localparam logic [4:0] VS_16     = 5'h13;
   localparam logic [4:0] VS_24     = 5'h18;
   localparam logic [4:0] S_LAST_64 = 5'h0b;
   localparam logic [4:0] S_LAST_80 = 5'h09;
   // i/o ports and controller indices
   localparam logic [7:0] IO_OPERATION_CONTROL_REGISTER     = 8'h84;
   localparam logic [7:0] IO_CTRL      = 8'h88;
   localparam logic [4:0] IDX_START_HI = 5'h0c;
   localparam logic [4:0] IDX_START_LO = 5'h0d;
   localparam int         OPERATION_CONTROL_REGISTER_PAGE   = 7;
   // synchroniser bit positions
   localparam int SY_RD  = 0;
   localparam int SY_WR  = 1;
   localparam int SY_SEL = 2;
   localparam int SY_IOW = 3;
   localparam int SY_FMT = 4;
   localparam int SY_INV = 5;
   localparam int SY_ALT = 6;
   localparam logic [6:0] SYNC_RST = 7'h0f;

   typedef struct packed {
      logic        rd_n;
      logic        wr_n;
      logic        sel_n;
      logic [10:0] addr;
      logic [7:0]  wdata;
   } vrd_cpu_bus_t;

   typedef struct packed {
      logic       wr_n;
      logic [7:0] addr;
      logic [7:0] data;
   } vrd_io_bus_t;

   typedef struct packed {
      logic        hsync;
      logic        vsync;
      logic        display_enable;
      logic [13:0] refresh_address;
      logic [4:0]  scan_row_address;
   } vrd_crt_t;

   typedef enum logic [2:0] {
      ST_IDLE, ST_WAIT, ST_READ, ST_WPRE, ST_WPULSE, ST_HOLD
   } vrd_cpu_st_t;

   typedef struct packed {
      logic [6:0]  sync1;
      logic [6:0]  sync2;
      logic [6:0]  sync3;
      logic [6:0]  filt;
      logic        iow_q;
      vrd_cpu_st_t cst;
      logic [3:0]  cnt;
      logic        wait_n;
      logic        latch_n;
      logic        ram_dis;
      logic        dvw_n;
      logic        buf_n;
      logic [7:0]  rdata;
      logic [7:0]  wdata;
      logic [7:0]  dout;
      logic        doe;
      logic [7:0]  operation_control_register;
      logic [4:0]  ctl_idx;
      logic [13:0] start;
      logic        phase;
      logic [4:0]  cyc;
      logic [6:0]  col;
      logic [4:0]  scan;
      logic [4:0]  row;
      logic [13:0] line_ma;
      logic [13:0] ma;
      logic        hs;
      logic        vs;
      logic        den;
      logic        den_p;
      logic [7:0]  code;
      logic [11:0] cg_addr;
      logic [7:0]  pattern;
      logic        shl_n;
      logic [7:0]  shreg;
      logic        video;
   } vrd_state_t;

   localparam vrd_state_t STATE_RST = '{sync1: SYNC_RST, sync2: SYNC_RST,
      sync3: SYNC_RST, filt: SYNC_RST, iow_q: 1'b1, cst: ST_IDLE,
      wait_n: 1'b1, latch_n: 1'b1, dvw_n: 1'b1, buf_n: 1'b1,
      phase: 1'b1, shl_n: 1'b1, default: '0};
endpackage

// ===== rtl/vrd_video_ram_display.sv
`timescale 1ns/1ps
module vrd_video_ram_display
   import vrd_pkg::*;
(
   // clock and reset
   input  wire logic         mclk,
   input  wire logic         arst_n,
   // processor memory side
   input  wire vrd_cpu_bus_t cpu,
   output logic [7:0]        cpu_rdata,
   output logic              cpu_rdata_oe,
   output logic              video_wait_n,
   // processor i/o writes
   input  wire vrd_io_bus_t  io,
   // mode levels
   input  wire logic         format_80,
   input  wire logic         inverse_select,
   input  wire logic         alternate_set_enable,
   // character generator
   output logic [11:0]       cg_addr,
   input  wire logic [7:0]   cg_data,
   // monitor side
   output vrd_crt_t          crt,
   output logic              video_out,
   output logic              video_phase_clock,
   // access strobes
   output logic              read_data_latch_strobe_n,
   output logic              video_ram_output_disable,
   output logic              delayed_video_write_n,
   output logic              video_buffer_enable_n
);

   vrd_state_t           st;
   vrd_state_t           next;
   logic [7:0]           vram [VRAM_DEPTH];
   logic                 rd;
   logic                 wr;
   logic                 sel;
   logic                 inv;
   logic                 alt;
   logic                 fmt80;
   logic                 iow_ev;
   logic                 samp;
   logic                 dot_en;
   logic                 ram_we;
   logic [VRAM_AW-1:0]   ram_addr;
   logic [7:0]           ram_q;
   logic [6:0]           agree;
   logic [6:0]           cols;
   logic [6:0]           h_last;
   logic [6:0]           hs0;
   logic [4:0]           rows;
   logic [4:0]           v_last;
   logic [4:0]           vs_row;
   logic [4:0]           s_last;
   logic                 a9;
   logic                 is_gfx;
   logic [3:0]           row_adj;
   logic [1:0]           gpair;
   logic [7:0]           gpat;

   assign rd     = ~st.filt[SY_RD];
   assign wr     = ~st.filt[SY_WR];
   assign sel    = ~st.filt[SY_SEL];
   assign fmt80  = st.filt[SY_FMT];
   assign inv    = st.filt[SY_INV];
   assign alt    = st.filt[SY_ALT];
   assign iow_ev = st.iow_q & ~st.filt[SY_IOW];
   assign samp   = (st.cyc == HALF);
   assign dot_en = (st.cyc & DOT_MASK) == DOT_MASK;
   assign agree  = ~(st.sync2 ^ st.sync3);

   // format selection
   assign cols   = fmt80 ? COLS_80 : COLS_64;
   assign h_last = fmt80 ? H_LAST_80 : H_LAST_64;
   assign hs0    = fmt80 ? HS_80 : HS_64;
   assign rows   = fmt80 ? ROWS_24 : ROWS_16;
   assign v_last = fmt80 ? V_LAST_24 : V_LAST_16;
   assign vs_row = fmt80 ? VS_24 : VS_16;
   assign s_last = fmt80 ? S_LAST_80 : S_LAST_64;

   // address multiplexer and ram port
   assign ram_addr = st.phase ? st.ma[VRAM_AW-1:0]
      : {st.operation_control_register[OPERATION_CONTROL_REGISTER_PAGE], cpu.addr[VRAM_AW-2:0]};
   assign ram_q  = st.ram_dis ? 8'h00 : vram[ram_addr];
   assign ram_we = (st.cst == ST_WPULSE) && (st.cnt == WR_PULSE_LAST);

   // character decode
   assign a9 = alt ? (~st.code[7] & st.code[6])
                   : (st.code[7] & st.code[6]);
   assign is_gfx  = st.code[7] & ~st.code[6];
   assign row_adj = is_gfx ? st.scan[3:0]
                           : 4'(st.scan[3:0] + ROW_ADD);
   assign gpair = (st.scan[3:0] < 4'h4) ? st.code[1:0]
                : (st.scan[3:0] < 4'h8) ? st.code[3:2] : st.code[5:4];
   assign gpat  = {{4{gpair[0]}}, {4{gpair[1]}}};

   // 2k by 8 store, written on the rising delayed write edge
   always_ff @(posedge mclk) begin
      if (ram_we) begin
         vram[ram_addr] <= st.wdata;
      end
   end

   always_comb begin
      next = st;
      // pin synchronisers
      next.sync1 = {alternate_set_enable, inverse_select, format_80,
                    io.wr_n, cpu.sel_n, cpu.wr_n, cpu.rd_n};
      next.sync2 = st.sync1;
      next.sync3 = st.sync2;
      next.filt  = (agree & st.sync3) | (~agree & st.filt);
      next.iow_q = st.filt[SY_IOW];

      // i/o port writes
      if (iow_ev) begin
         if (io.addr[7:2] == IO_OPERATION_CONTROL_REGISTER[7:2]) begin
            next.operation_control_register = io.data;
         end
         if (io.addr[7:2] == IO_CTRL[7:2]) begin
            if (!io.addr[0]) begin
               next.ctl_idx = io.data[4:0];
            end else if (st.ctl_idx == IDX_START_HI) begin
               next.start[13:8] = io.data[5:0];
            end else if (st.ctl_idx == IDX_START_LO) begin
               next.start[7:0] = io.data;
            end
         end
      end

      // character period and phase clock
      next.cyc   = 5'(st.cyc + 5'h01);
      next.phase = next.cyc < HALF;
      next.shl_n = next.cyc < SHL_START;

      // display controller counters
      if (st.cyc == CYC_LAST) begin
         next.col = 7'(st.col + 7'h01);
         if (st.col >= h_last) begin
            next.col  = '0;
            next.scan = 5'(st.scan + 5'h01);
            if (st.scan >= s_last) begin
               next.scan    = '0;
               next.row     = 5'(st.row + 5'h01);
               next.line_ma = 14'(st.line_ma + {7'h00, cols});
               if (st.row >= v_last) begin
                  next.row     = '0;
                  next.line_ma = st.start;
               end
            end
         end
      end
      next.ma  = 14'(next.line_ma + {7'h00, next.col});
      next.den = (next.col < cols) && (next.row < rows);
      next.hs  = (next.col >= hs0) &&
                 (next.col < 7'(hs0 + HS_WIDTH));
      next.vs  = (next.row == vs_row);

      // refresh fetch and pattern selection
      if (st.cyc == FETCH_CYC) begin
         next.code  = inv ? {1'b0, ram_q[6:0]} : ram_q;
         next.den_p = st.den;
      end
      if (samp) begin
         next.cg_addr = {a9, st.code[6:0], row_adj};
      end
      if (st.cyc == PAT_CYC) begin
         next.pattern = !st.den_p ? 8'h00
                      : (is_gfx ? gpat : cg_data);
      end
      if (dot_en) begin
         if (!st.shl_n) begin
            next.shreg = st.pattern;
         end else begin
            next.shreg = {st.shreg[6:0], 1'b0};
         end
         next.video = next.shreg[7];
      end

      // processor access sequencer
      next.doe  = rd & sel;
      next.dout = st.rdata;
      case (st.cst)
         ST_IDLE: begin
            if (sel && (rd || wr)) begin
               next.wait_n = 1'b0;
               next.cst    = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!sel) begin
               next.wait_n = 1'b1;
               next.cst    = ST_IDLE;
            end else if (samp && (rd || wr)) begin
               next.wait_n = 1'b1;
               next.cnt    = '0;
               if (rd) begin
                  next.cst = ST_READ;
               end else begin
                  next.cst     = ST_WPRE;
                  next.ram_dis = 1'b1;
               end
            end
         end
         ST_READ: begin
            next.cnt = 4'(st.cnt + 4'h1);
            if (st.cnt == RD_LAST) begin
               next.latch_n = 1'b0;
               next.rdata   = ram_q;
               next.cst     = ST_HOLD;
            end
         end
         ST_WPRE: begin
            next.cnt = 4'(st.cnt + 4'h1);
            if (st.cnt == WR_DLY_LAST) begin
               next.dvw_n = 1'b0;
               next.buf_n = 1'b0;
               next.wdata = cpu.wdata;
               next.cnt   = '0;
               next.cst   = ST_WPULSE;
            end
         end
         ST_WPULSE: begin
            next.cnt = 4'(st.cnt + 4'h1);
            if (st.cnt == WR_PULSE_LAST) begin
               next.dvw_n   = 1'b1;
               next.buf_n   = 1'b1;
               next.ram_dis = 1'b0;
               next.cst     = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (!sel) begin
               next.latch_n = 1'b1;
               next.cst     = ST_IDLE;
            end
         end
         default: begin
            next.cst = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st <= STATE_RST;
      end else begin
         st <= next;
      end
   end

   // outputs
   assign cpu_rdata                = st.dout;
   assign cpu_rdata_oe             = st.doe;
   assign video_wait_n             = st.wait_n;
   assign cg_addr                  = st.cg_addr;
   assign crt                      = {st.hs, st.vs, st.den, st.ma, st.scan};
   assign video_out                = st.video;
   assign video_phase_clock        = st.phase;
   assign read_data_latch_strobe_n = st.latch_n;
   assign video_ram_output_disable = st.ram_dis;
   assign delayed_video_write_n    = st.dvw_n;
   assign video_buffer_enable_n    = st.buf_n;

   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);

   addr_mux_a: assert property (
      st.phase |-> ram_addr == st.ma[VRAM_AW-1:0])
      else $error("refresh address not on ram in high phase");
   page_bit_a: assert property (
      !st.phase |-> ram_addr[VRAM_AW-1] == st.operation_control_register[OPERATION_CONTROL_REGISTER_PAGE])
      else $error("page select not on processor A10");
   wait_hold_a: assert property (
      (st.cst == ST_WAIT) |-> !st.wait_n)
      else $error("wait released while waiting");
   wait_release_a: assert property (
      $rose(st.wait_n) && (st.cst != ST_IDLE) |-> $past(samp) && !st.phase)
      else $error("wait released off the sample edge");
   latch_delay_a: assert property (
      $rose(st.wait_n) && (st.cst == ST_READ) |-> ##12 $fell(st.latch_n))
      else $error("latch strobe not 240 ns after release");
   data_drive_a: assert property (
      st.doe |-> $past(rd && sel))
      else $error("data driven without read and select");
   out_disable_a: assert property (
      !st.dvw_n |-> st.ram_dis && !st.phase)
      else $error("ram output enabled during write");
   write_delay_a: assert property (
      $rose(st.wait_n) && (st.cst == ST_WPRE) |-> ##2 $fell(st.dvw_n))
      else $error("delayed write not 30 ns after release");
   write_pulse_a: assert property (
      $fell(st.dvw_n) |-> (!st.dvw_n && !st.buf_n) [*6]
                          ##1 (st.dvw_n && st.buf_n))
      else $error("write pulse not 120 ns");
   alt_set_a: assert property (
      (st.cyc == PAT_CYC) |-> st.cg_addr[11] == $past(a9, 2))
      else $error("A9 decode wrong");
   row_adjust_a: assert property (
      samp |=> st.cg_addr[3:0] == (is_gfx ? st.scan[3:0]
                                  : 4'(st.scan[3:0] - 4'h1)))
      else $error("row adjust wrong");
   shift_load_a: assert property (
      dot_en && !st.shl_n |=> st.shreg == $past(st.pattern))
      else $error("shift register load missed");
   refresh_safe_a: assert property (
      st.phase |-> !st.ram_dis && !ram_we)
      else $error("processor access in refresh phase");

   read_done_c: cover property ($fell(st.latch_n));
   write_done_c: cover property ($rose(st.dvw_n));
   graphic_cell_c: cover property (samp && is_gfx && st.den_p);
   page_one_c: cover property (ram_we && st.operation_control_register[OPERATION_CONTROL_REGISTER_PAGE]);

endmodule

// ===== sim/vrd_host_model.sv
`timescale 1ns/1ps
module vrd_host_model
   import vrd_pkg::*;
(
   // clock
   input  wire logic       mclk,
   // processor buses
   output vrd_cpu_bus_t    cpu,
   output vrd_io_bus_t     io,
   // device answers
   input  wire logic [7:0] cpu_rdata,
   input  wire logic       cpu_rdata_oe,
   input  wire logic       video_wait_n,
   input  wire logic       video_phase_clock,
   input  wire logic       read_data_latch_strobe_n,
   input  wire logic       video_ram_output_disable,
   input  wire logic       delayed_video_write_n,
   input  wire logic       video_buffer_enable_n
);
   initial begin
      cpu = '{rd_n: 1'b1, wr_n: 1'b1, sel_n: 1'b1, default: '0};
      io  = '{wr_n: 1'b1, default: '0};
   end

   // i/o write, strobe held four edges, lines inverted once released
   task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      io = '{wr_n: 1'b0, addr: a, data: d};
      repeat (4) @(negedge mclk);
      io.wr_n = 1'b1;
      @(negedge mclk);
      io.addr = ~a;
      io.data = ~d;
      repeat (5) @(negedge mclk);
   endtask

   // one video ram access, request held until the device answers
   task automatic mem_op(input logic wr, input logic [10:0] a,
      input logic [7:0] d, output logic [7:0] rd, output int lat,
      output int pulse, output logic ph, output logic side,
      output logic ok);
      int n;
      ok = 1'b1;
      side = 1'b1;
      lat = 0;
      pulse = 0;
      rd = '0;
      n = 0;
      @(negedge mclk);
      cpu = '{rd_n: wr, wr_n: ~wr, sel_n: 1'b0, addr: a, wdata: d};
      while (video_wait_n !== 1'b0 && n < 40) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= 40)
         ok = 1'b0;
      n = 0;
      while (video_wait_n !== 1'b1 && n < 80) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (n >= 80)
         ok = 1'b0;
      ph = video_phase_clock;
      while ((wr ? delayed_video_write_n : read_data_latch_strobe_n)
             !== 1'b0 && lat < 40) begin
         @(posedge mclk);
         #1;
         lat++;
      end
      if (wr) begin
         while (delayed_video_write_n === 1'b0 && pulse < 20) begin
            side &= video_buffer_enable_n === 1'b0
                    && video_ram_output_disable === 1'b1
                    && cpu_rdata_oe === 1'b0;
            @(posedge mclk);
            #1;
            pulse++;
         end
         side &= video_buffer_enable_n === 1'b1;
      end else begin
         repeat (2) @(posedge mclk);
         #1;
         rd = cpu_rdata;
         side = cpu_rdata_oe === 1'b1;
      end
      @(negedge mclk);
      cpu = '{rd_n: 1'b1, wr_n: 1'b1, sel_n: 1'b1, addr: ~a, wdata: ~d};
      repeat (6) @(negedge mclk);
   endtask
endmodule

// ===== sim/vrd_video_ram_display_tb_top.sv
`timescale 1ns/1ps
module vrd_video_ram_display_tb_top
   import vrd_pkg::*;
();
   logic         mclk;
   logic         arst_n;
   vrd_cpu_bus_t cpu;
   vrd_io_bus_t  io;
   logic [7:0]   cpu_rdata;
   logic         cpu_rdata_oe;
   logic         video_wait_n;
   logic         format_80;
   logic         inverse_select;
   logic         alternate_set_enable;
   logic [11:0]  cg_addr;
   logic [11:0]  cg_prev;
   logic [7:0]   cg_data;
   vrd_crt_t     crt;
   logic         video_out;
   logic         video_phase_clock;
   logic         latch_n;
   logic         ram_dis;
   logic         dvw_n;
   logic         buf_n;
   logic         cg_chk;
   logic         page;
   logic         den_prev;
   logic [13:0]  ma_prev;
   logic [7:0]   vpend;
   logic [7:0]   vcur;
   logic [4:0]   lcnt = 5'h00;
   logic [4:0]   dcnt = 5'h00;
   logic [7:0]   mem [0:VRAM_DEPTH-1];
   logic [10:0]  addrs [$];
   int           error_cnt;
   int           compares;

   initial mclk = 1'b0;
   always #10 mclk = ~mclk;
   assign cg_data = cg_addr[7:0] ^ cg_addr[11:4];

   vrd_video_ram_display u_dut (.mclk(mclk), .arst_n(arst_n), .cpu(cpu),
      .cpu_rdata(cpu_rdata), .cpu_rdata_oe(cpu_rdata_oe),
      .video_wait_n(video_wait_n), .io(io), .format_80(format_80),
      .inverse_select(inverse_select),
      .alternate_set_enable(alternate_set_enable), .cg_addr(cg_addr),
      .cg_data(cg_data), .crt(crt), .video_out(video_out),
      .video_phase_clock(video_phase_clock),
      .read_data_latch_strobe_n(latch_n),
      .video_ram_output_disable(ram_dis),
      .delayed_video_write_n(dvw_n), .video_buffer_enable_n(buf_n));

   vrd_host_model u_host (.mclk(mclk), .cpu(cpu), .io(io),
      .cpu_rdata(cpu_rdata), .cpu_rdata_oe(cpu_rdata_oe),
      .video_wait_n(video_wait_n), .video_phase_clock(video_phase_clock),
      .read_data_latch_strobe_n(latch_n), .video_ram_output_disable(ram_dis),
      .delayed_video_write_n(dvw_n), .video_buffer_enable_n(buf_n));

   task automatic results();
      if (error_cnt == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp,
                          input string msg);
      compares++;
      if (got !== exp || $isunknown(got)) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic chk_cnt(input int got, input int exp, input string msg);
      compares++;
      if (got != exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %0d exp %0d", $time, msg, got,
                  exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp, input string msg);
      compares++;
      if (got !== exp || $isunknown(got)) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %b", $time, msg, got);
      end
   endtask

   function automatic logic sig(input int which);
      return which ? crt.hsync : crt.display_enable;
   endfunction

   // length of the next full high run of enable or hsync
   task automatic run_len(input int which, output int len);
      int n;
      n = 0;
      len = 0;
      while (sig(which) !== 1'b0 && n < 8000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      while (sig(which) !== 1'b1 && n < 8000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      while (sig(which) === 1'b1 && len < 8000) begin
         @(posedge mclk);
         #1;
         len++;
      end
      if (n >= 8000 || len >= 8000) begin
         error_cnt++;
         results();
      end
   endtask

   task automatic set_page(input logic p);
      page = p;
      u_host.io_wr(IO_OPERATION_CONTROL_REGISTER, {p, 7'($urandom)});
   endtask

   task automatic vram(input logic wr, input logic [10:0] a,
                       input logic [7:0] d);
      logic [7:0] rd;
      int         lat;
      int         pulse;
      logic       ph;
      logic       side;
      logic       ok;
      u_host.mem_op(wr, a, d, rd, lat, pulse, ph, side, ok);
      if (!ok) begin
         error_cnt++;
         results();
      end
      chk_flag(ph, 1'b0, "wait release phase");
      if (wr) begin
         mem[{page, a[9:0]}] = d;
         chk_cnt(lat, WR_DELAY_CYC, "write delay");
         chk_cnt(pulse, WR_PULSE_CYC, "write pulse");
         chk_flag(side, 1'b1, "write strobes");
      end else begin
         chk_cnt(lat, RD_LATCH_CYC, "latch delay");
         chk_val(rd, mem[{page, a[9:0]}], "read data");
         chk_flag(side, 1'b1, "read drive");
      end
      chk_flag(cpu_rdata_oe, 1'b0, "bus released");
   endtask

   // character generator address against code and scan row
   always @(negedge mclk) begin
      if (arst_n && cg_chk && cg_addr !== cg_prev) begin
         if (inverse_select) begin
            chk_flag(cg_addr[11], alternate_set_enable & cg_addr[10],
                     "alternate bit");
            if (crt.display_enable)
               chk_val({4'h0, cg_addr[3:0]},
                  {4'h0, 4'(crt.scan_row_address[3:0] + ROW_ADD)}, "row");
         end else if (cg_addr[10] === 1'b0)
            chk_flag(cg_addr[11], 1'b0, "alternate bit");
      end
      cg_prev <= cg_addr;
   end

   // serial video: fetched pattern shifted out msb first, 4 clocks a dot
   always @(negedge mclk) begin
      if (lcnt != 5'h00)
         lcnt <= lcnt - 5'h01;
      if (dcnt != 5'h00)
         dcnt <= dcnt - 5'h01;
      if (dcnt[1:0] == 2'h3)
         chk_flag(video_out, vcur[dcnt[4:2]], "serial video");
      if (lcnt == 5'h01) begin
         vcur <= vpend;
         dcnt <= 5'h1f;
      end
      if (arst_n && cg_chk && inverse_select && cg_addr !== cg_prev) begin
         vpend <= crt.display_enable ? cg_data : 8'h00;
         lcnt  <= 5'h0f;
      end
   end

   // refresh address steps by one per character inside active video
   always @(negedge mclk) begin
      if (arst_n && den_prev === 1'b1 && crt.display_enable
          && crt.refresh_address !== ma_prev)
         chk_val(crt.refresh_address[7:0], 8'(ma_prev[7:0] + 8'h01),
                 "refresh step");
      den_prev <= crt.display_enable;
      ma_prev  <= crt.refresh_address;
   end

   initial begin
      int den_len;
      int hs_len;
      logic [13:0] start_exp;
      error_cnt = 0;
      compares = 0;
      format_80 = 1'b0;
      inverse_select = 1'b1;
      alternate_set_enable = 1'b0;
      cg_chk = 1'b0;
      page = 1'b0;
      arst_n = 1'b0;
      repeat (5) @(negedge mclk);
      arst_n = 1'b1;
      void'($urandom(32'hbe56));
      // fill the cells refreshed in the first text row
      for (int a = 0; a <= int'(H_LAST_64); a++)
         vram(1'b1, 11'(a), 8'($urandom));
      for (int m = 0; m < 4; m++) begin
         inverse_select = m[1];
         alternate_set_enable = m[0];
         cg_chk = 1'b0;
         repeat (100) @(negedge mclk);
         cg_chk = 1'b1;
         repeat (600) @(negedge mclk);
      end
      cg_chk = 1'b0;
      for (int f = 0; f < 2; f++) begin
         format_80 = f[0];
         repeat (2) run_len(0, den_len);
         run_len(1, hs_len);
         chk_cnt(den_len, (f ? int'(COLS_80) : int'(COLS_64)) * 32,
                 "active width");
         chk_cnt(hs_len, int'(HS_WIDTH) * 32, "hsync width");
      end
      for (int p = 0; p < 2; p++) begin
         set_page(p[0]);
         for (int k = 0; k < 6; k++) begin
            addrs.push_back(k == 0 ? 11'h000 : k == 1 ? 11'h3ff
                            : 11'($urandom));
            vram(1'b1, {addrs[$][10:1], 1'b0} | 11'(k & 1), 8'($urandom));
            addrs[$][0] = k[0];
            addrs[$][10] = p[0];
         end
      end
      foreach (addrs[i]) begin
         if (page !== addrs[i][10])
            set_page(addrs[i][10]);
         vram(1'b0, {1'($urandom), addrs[i][9:0]}, 8'($urandom));
      end
      // start address through index and data ports, one refused index
      start_exp = 14'($urandom);
      u_host.io_wr(IO_CTRL, {3'h0, IDX_START_HI});
      u_host.io_wr(IO_CTRL | 8'h01, {2'h3, start_exp[13:8]});
      u_host.io_wr(IO_CTRL, {3'h0, IDX_START_LO});
      u_host.io_wr(IO_CTRL | 8'h01, start_exp[7:0]);
      u_host.io_wr(IO_CTRL, 8'h0e);
      u_host.io_wr(IO_CTRL | 8'h01, ~start_exp[7:0]);
      chk_val({2'h0, u_dut.st.start[13:8]}, {2'h0, start_exp[13:8]},
              "start high");
      chk_val(u_dut.st.start[7:0], start_exp[7:0], "start low");
      results();
   end
endmodule
